// [shared/alarm_bank_consts.vh]
// Purpose: constants for the module alarm and monitor register bank
// Assumes: 16-bit register data, 16-bit register addresses
// Notes:   offsets are word addresses on the plain register port
`ifndef ALARM_BANK_CONSTS_VH
`define ALARM_BANK_CONSTS_VH

// ****************************************
// register addresses
// ****************************************
`define ADDR_MOD_FLAGS        16'hA01F
`define ADDR_MOD_MASK         16'hA080
`define ADDR_MON_MOD_TEMP     16'hA040
`define ADDR_MON_MOD_VCC      16'hA041
`define ADDR_MON_AMP_BIAS     16'hA042
`define ADDR_IRQ_STATUS       16'hA0F0
`define ADDR_IRQ_MASK         16'hA0F1
`define ADDR_LANE_FLAGS_BASE  16'hA200
`define ADDR_LANE_MASK_BASE   16'hA280
`define ADDR_LANE_MON_BASE    16'hA2C0
// lane flag and lane mask blocks span 2**4 words, lane monitors 2**6
`define LANE_BLK_LOG2         4'h4
`define LANE_MON_BLK_LOG2     4'h6

// ****************************************
// field layout and reset values
// ****************************************
`define MOD_FLAG_W            12
`define MOD_FLAG_RESET        12'h000
`define MOD_MASK_RESET        12'h000
`define LANE_FLAG_RESET       16'h0000
`define LANE_MASK_RESET       16'h0000
`define MON_RESET             16'h0000
`define LANE_COUNT            16
`define LANE_MON_WORDS        64
// flag bit positions inside the module flag word
`define BIT_TEMP_HI_ALARM     11
`define BIT_TEMP_HI_WARN      10
`define BIT_TEMP_LO_WARN      9
`define BIT_TEMP_LO_ALARM     8
`define BIT_VCC_HI_ALARM      7
`define BIT_VCC_HI_WARN       6
`define BIT_VCC_LO_WARN       5
`define BIT_VCC_LO_ALARM      4
`define BIT_AMP_HI_ALARM      3
`define BIT_AMP_HI_WARN       2
`define BIT_AMP_LO_WARN       1
`define BIT_AMP_LO_ALARM      0
// per-lane monitor word kinds: lane * 4 + kind
`define MON_KIND_BIAS         2'h0
`define MON_KIND_TXPWR        2'h1
`define MON_KIND_TEMP         2'h2
`define MON_KIND_RXPWR        2'h3
// interrupt status and mask bits
`define IRQ_W                 3
`define IRQ_BIT_MOD_FLAG      0
`define IRQ_BIT_LANE_FLAG     1
`define IRQ_BIT_REFRESH       2
`define IRQ_RESET             3'h0

// ****************************************
// monitor scaling, full code span 16'hFFFF
// ****************************************
`define BIAS_FULL_SCALE_UA    131072
`define PWR_FULL_SCALE_TENTH_UW 65535

// ****************************************
// timing
// ****************************************
// 125000 kHz clock and 100 ms period, sized to the 24-bit timer
`define CLK_KHZ               24'h01E848
`define REFRESH_MS            24'h000064
`define REFRESH_CYCLES        (`REFRESH_MS * `CLK_KHZ)

`endif

// [core/monitor_refresh_timer.v]
// Purpose: free running period divider, one-cycle tick per period
// Assumes: single clock ref_clk, asynchronous active-low reset
// Notes:   first tick comes one full period after reset release
`timescale 1ns/10ps
`default_nettype none
`include "alarm_bank_consts.vh"

module monitor_refresh_timer #(
  parameter [23:0] PERIOD_CYCLES = `REFRESH_CYCLES
) (
  input  wire ref_clk,
  input  wire resetn,
  output reg  tick_q
);

  // ****************************************
  // period counter
  // ****************************************
  reg  [23:0] count_q;
  wire        wrap;

  assign wrap = (count_q == PERIOD_CYCLES - 24'h000001);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= 24'h000000;
      tick_q  <= 1'b0;
    end else begin
      tick_q <= wrap; // R10
      if (wrap) begin
        count_q <= 24'h000000;
      end else begin
        count_q <= count_q + 24'h000001;
      end
    end
  end

endmodule
`default_nettype wire

// [core/module_alarm_monitor_bank.v]
// Purpose: module alarm/warning flags, monitor values, enable masks, global alarm
// Assumes: plain register port, read data in the cycle after the read strobe
// Notes:   flag condition inputs come from comparators outside this block
//
// Notes on behaviour
// R1: the module flag word is 16 bits, read only, resets to zero, bits 15 to 12 read zero.
// R2: module temperature flags sit at bits 11 high alarm, 10 high warning, 9 low warning, 8 low alarm.
// R3: supply voltage flags sit at bits 7 high alarm, 6 high warning, 5 low warning, 4 low alarm.
// R4: amplifier bias flags sit at bits 3 high alarm, 2 high warning, 1 low warning, 0 low alarm.
// R5: each lane has a laser bias monitor word spanning 0 to 131.072 mA.
// R6: each lane has a transmit power monitor word spanning 0 to 6.5535 mW.
// R7: each lane has a receive power monitor word spanning 0 to 6.5535 mW.
// R8: each lane has a laser temperature monitor word in degrees Celsius.
// R9: three module-level monitor words hold module temperature, 3.3 V supply and amplifier bias.
// R10: module-level monitor words refresh by themselves every 100 ms.
// R11: every flag has an enable mask bit that the host sets or clears.
// R12: a flag whose mask bit is set never drives the global alarm.
// R13: any asserted flag with a clear mask bit drives the global alarm.
// R14: sixteen read-only per-lane flag words exist, one per lane, lanes in use vary.
// R15: each monitor word is a 16-bit unsigned code linear from zero to full scale.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "alarm_bank_consts.vh"

module module_alarm_monitor_bank #(
  parameter [23:0] REFRESH_CYCLES = `REFRESH_CYCLES
) (
  input  wire         ref_clk,
  input  wire         resetn,
  input  wire [15:0]  reg_addr,
  input  wire [15:0]  reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output reg  [15:0]  reg_rdata_q,
  input  wire [11:0]  mod_flag_cond,
  input  wire [255:0] lane_flag_cond,
  input  wire [15:0]  mod_temp_code,
  input  wire [15:0]  mod_vcc_code,
  input  wire [15:0]  amp_bias_code,
  input  wire [255:0] lane_bias_code,
  input  wire [255:0] lane_txpwr_code,
  input  wire [255:0] lane_temp_code,
  input  wire [255:0] lane_rxpwr_code,
  output wire         global_alarm_out,
  output wire         irq_out
);

  // ****************************************
  // address decode helper
  // ****************************************
  // true when addr falls in the aligned block of 2**blk_log2 words at base
  function in_block;
    input [15:0] addr;
    input [15:0] base;
    input [3:0]  blk_log2;
    reg   [15:0] hi_mask;
    begin
      hi_mask  = 16'hFFFF << blk_log2;
      in_block = ((addr & hi_mask) == (base & hi_mask));
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg  [11:0] fault_alarm_warning_status_q;
  reg  [11:0] mod_mask_q;
  reg  [15:0] mon_mod_temp_q;
  reg  [15:0] mon_mod_vcc_q;
  reg  [15:0] mon_amp_bias_q;
  reg  [15:0] lane_flags_q [0:15];
  reg  [15:0] lane_mask_q  [0:15];
  reg  [15:0] lane_mon_q   [0:63];
  reg  [2:0]  irq_status_q;
  reg  [2:0]  irq_mask_q;
  reg         mod_active_q;
  reg         lane_any_q;
  reg  [15:0] rd_mux;
  reg  [2:0]  irq_status_d;
  wire        refresh_tick;
  wire [15:0] lane_active;
  wire [15:0] mod_flag_word;
  wire        mod_active;
  wire        lane_any;
  wire        wr_mod_mask;
  wire        wr_lane_mask;
  wire        wr_irq_status;
  wire        wr_irq_mask;
  wire [3:0]  lane_sel;
  wire [5:0]  mon_sel;
  wire [2:0]  irq_set;
  wire        hit_mod_mask;
  wire        hit_lane_mask;
  wire        hit_irq_status;
  wire        hit_irq_mask;
  integer     k;

  assign lane_sel = reg_addr[3:0];
  assign mon_sel  = reg_addr[5:0];

  // ****************************************
  // refresh period
  // ****************************************
  monitor_refresh_timer #(
    .PERIOD_CYCLES (REFRESH_CYCLES)
  ) u_refresh (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick_q  (refresh_tick)
  );

  // ****************************************
  // module flags and module monitors
  // ****************************************
  // flags follow the live comparator outputs, they do not latch
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fault_alarm_warning_status_q <= `MOD_FLAG_RESET; // R1
    end else begin
      fault_alarm_warning_status_q <= mod_flag_cond; // R2 R3 R4
    end
  end

  assign mod_flag_word = {4'h0, fault_alarm_warning_status_q}; // R1

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mon_mod_temp_q <= `MON_RESET;
      mon_mod_vcc_q  <= `MON_RESET;
      mon_amp_bias_q <= `MON_RESET;
    end else if (refresh_tick) begin
      mon_mod_temp_q <= mod_temp_code; // R9 R10 R15
      mon_mod_vcc_q  <= mod_vcc_code; // R9 R10
      mon_amp_bias_q <= amp_bias_code; // R9 R10
    end
  end

  // ****************************************
  // per-lane flags and monitors
  // ****************************************
  // lanes not fitted should have their condition inputs tied low
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (k = 0; k < `LANE_COUNT; k = k + 1) begin
        lane_flags_q[k] <= `LANE_FLAG_RESET;
      end
    end else begin
      for (k = 0; k < `LANE_COUNT; k = k + 1) begin
        lane_flags_q[k] <= lane_flag_cond[k*16 +: 16]; // R14
      end
    end
  end

  // lane monitors share the module refresh tick so a read set is coherent
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (k = 0; k < `LANE_MON_WORDS; k = k + 1) begin
        lane_mon_q[k] <= `MON_RESET;
      end
    end else if (refresh_tick) begin
      for (k = 0; k < `LANE_COUNT; k = k + 1) begin
        lane_mon_q[k*4 + 0] <= lane_bias_code[k*16 +: 16]; // R5 R15
        lane_mon_q[k*4 + 1] <= lane_txpwr_code[k*16 +: 16]; // R6 R15
        lane_mon_q[k*4 + 2] <= lane_temp_code[k*16 +: 16]; // R8
        lane_mon_q[k*4 + 3] <= lane_rxpwr_code[k*16 +: 16]; // R7 R15
      end
    end
  end

  // ****************************************
  // write decode
  // ****************************************
  // shared by write decode and read mux so both see one map
  assign hit_mod_mask   = (reg_addr == `ADDR_MOD_MASK);
  assign hit_lane_mask  = in_block(reg_addr, `ADDR_LANE_MASK_BASE, `LANE_BLK_LOG2);
  assign hit_irq_status = (reg_addr == `ADDR_IRQ_STATUS);
  assign hit_irq_mask   = (reg_addr == `ADDR_IRQ_MASK);

  assign wr_mod_mask   = reg_wr && hit_mod_mask;
  assign wr_lane_mask  = reg_wr && hit_lane_mask;
  assign wr_irq_status = reg_wr && hit_irq_status;
  assign wr_irq_mask   = reg_wr && hit_irq_mask;

  // ****************************************
  // enable masks
  // ****************************************
  // masks gate the global alarm and the flag-rise interrupt status bits, flag reads are unaffected
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mod_mask_q <= `MOD_MASK_RESET;
    end else if (wr_mod_mask) begin
      mod_mask_q <= reg_wdata[11:0]; // R11
    end
  end

  // one mask word per lane, picked by the low address bits
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (k = 0; k < `LANE_COUNT; k = k + 1) begin
        lane_mask_q[k] <= `LANE_MASK_RESET;
      end
    end else if (wr_lane_mask) begin
      lane_mask_q[lane_sel] <= reg_wdata; // R11
    end
  end

  // ****************************************
  // global alarm
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `LANE_COUNT; g = g + 1) begin : g_lane
      assign lane_active[g] = |(lane_flags_q[g] & ~lane_mask_q[g]); // R12 R13
    end
  endgenerate

  assign mod_active = |(fault_alarm_warning_status_q & ~mod_mask_q); // R12 R13
  assign lane_any   = |lane_active;
  // built only from flops, so it never glitches on bus activity
  assign global_alarm_out = mod_active | lane_any; // R13

  // ****************************************
  // interrupt status
  // ****************************************
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mod_active_q <= 1'b0;
      lane_any_q   <= 1'b0;
    end else begin
      mod_active_q <= mod_active;
      lane_any_q   <= lane_any;
    end
  end

  assign irq_set = {refresh_tick, lane_any & ~lane_any_q, mod_active & ~mod_active_q};

  // a new event in the clearing cycle survives the clear
  always @* begin
    irq_status_d = irq_status_q;
    if (wr_irq_status) begin
      irq_status_d = irq_status_q & ~reg_wdata[2:0];
    end
    irq_status_d = irq_status_d | irq_set;
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status_q <= `IRQ_RESET;
      irq_mask_q   <= `IRQ_RESET;
    end else begin
      irq_status_q <= irq_status_d;
      if (wr_irq_mask) begin
        irq_mask_q <= reg_wdata[2:0];
      end
    end
  end

  // mask bit high lets its status bit onto irq_out
  assign irq_out = |(irq_status_q & irq_mask_q);

  // ****************************************
  // read path
  // ****************************************
  // unmapped addresses read zero
  always @* begin
    rd_mux = 16'h0000;
    if (reg_addr == `ADDR_MOD_FLAGS) begin
      rd_mux = mod_flag_word; // R1
    end else if (hit_mod_mask) begin
      rd_mux = {4'h0, mod_mask_q};
    end else if (reg_addr == `ADDR_MON_MOD_TEMP) begin
      rd_mux = mon_mod_temp_q;
    end else if (reg_addr == `ADDR_MON_MOD_VCC) begin
      rd_mux = mon_mod_vcc_q;
    end else if (reg_addr == `ADDR_MON_AMP_BIAS) begin
      rd_mux = mon_amp_bias_q;
    end else if (hit_irq_status) begin
      rd_mux = {13'h0000, irq_status_q};
    end else if (hit_irq_mask) begin
      rd_mux = {13'h0000, irq_mask_q};
    end else if (in_block(reg_addr, `ADDR_LANE_FLAGS_BASE, `LANE_BLK_LOG2)) begin
      rd_mux = lane_flags_q[lane_sel]; // R14
    end else if (hit_lane_mask) begin
      rd_mux = lane_mask_q[lane_sel];
    end else if (in_block(reg_addr, `ADDR_LANE_MON_BASE, `LANE_MON_BLK_LOG2)) begin
      rd_mux = lane_mon_q[mon_sel];
    end
  end

  // data stands only in the cycle after the strobe, zero otherwise
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// [verification/alarm_bank_chk.sv]
// Purpose: port checks for the alarm bank
// Assumes: one clock, async active-low reset
// Notes:   masks tracked by snooping bus writes
`timescale 1ns/10ps
`default_nettype none
`include "alarm_bank_consts.vh"
module alarm_bank_chk #(
  parameter [23:0] REFRESH_CYCLES = 24'd16
) (
  input wire logic         ref_clk,
  input wire logic         resetn,
  input wire logic [15:0]  reg_addr,
  input wire logic [15:0]  reg_wdata,
  input wire logic         reg_wr,
  input wire logic         reg_rd,
  input wire logic [15:0]  reg_rdata_q,
  input wire logic [11:0]  mod_flag_cond,
  input wire logic [255:0] lane_flag_cond,
  input wire logic         global_alarm_out,
  input wire logic         irq_out
);
  // ****************************************
  // shadow flags and masks
  // ****************************************
  reg  [11:0]  mf_q;
  reg  [11:0]  mm_q;
  reg  [255:0] lf_q;
  reg  [255:0] lm_q;
  wire         exp_alarm = (|(mf_q & ~mm_q)) | (|(lf_q & ~lm_q));
  wire         rd_flag = reg_rd && reg_addr == `ADDR_MOD_FLAGS;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mf_q <= 12'h000;
      mm_q <= 12'h000;
      lf_q <= 256'h0;
      lm_q <= 256'h0;
    end else begin
      mf_q <= mod_flag_cond;
      lf_q <= lane_flag_cond;
      if (reg_wr && reg_addr == `ADDR_MOD_MASK) begin
        mm_q <= reg_wdata[11:0];
      end
      if (reg_wr && reg_addr[15:4] == 12'hA28) begin
        lm_q[reg_addr[3:0]*16 +: 16] <= reg_wdata;
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_rsvd; rd_flag |=> reg_rdata_q[15:12] == 4'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("flag word top bits set");
  property p_temp; rd_flag |=> reg_rdata_q[11:8] == $past(mf_q[11:8]); endproperty
  a_temp: assert property (p_temp) else $error("temperature flags wrong");
  property p_vcc; rd_flag |=> reg_rdata_q[7:4] == $past(mf_q[7:4]); endproperty
  a_vcc: assert property (p_vcc) else $error("supply flags wrong");
  property p_amp; rd_flag |=> reg_rdata_q[3:0] == $past(mf_q[3:0]); endproperty
  a_amp: assert property (p_amp) else $error("amplifier flags wrong");
  property p_on; exp_alarm |-> global_alarm_out; endproperty
  a_on: assert property (p_on) else $error("alarm missing");
  property p_off; !exp_alarm |-> !global_alarm_out; endproperty
  a_off: assert property (p_off) else $error("masked flag raised alarm");
  property p_mask; reg_rd && reg_addr == `ADDR_MOD_MASK |=> reg_rdata_q == {4'h0, $past(mm_q)}; endproperty
  a_mask: assert property (p_mask) else $error("mask readback wrong");
  property p_lane;
    reg_rd && reg_addr[15:4] == 12'hA20 |=> reg_rdata_q == $past(lf_q[reg_addr[3:0]*16 +: 16]);
  endproperty
  a_lane: assert property (p_lane) else $error("lane flag word wrong");
  c_alarm: cover property (global_alarm_out ##1 !global_alarm_out);
  c_irq: cover property (irq_out);
  c_flag: cover property (rd_flag ##1 reg_rdata_q != 16'h0000);
endmodule
bind module_alarm_monitor_bank alarm_bank_chk #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .mod_flag_cond(mod_flag_cond),
  .lane_flag_cond(lane_flag_cond), .global_alarm_out(global_alarm_out), .irq_out(irq_out));
`default_nettype wire

// [verification/host_model.sv]
// Purpose: host side of the register port
// Assumes: strobes one cycle, read data one cycle later
// Notes:   released lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        ref_clk,
  output var logic [15:0]  reg_addr,
  output var logic [15:0]  reg_wdata,
  output var logic         reg_wr,
  output var logic         reg_rd,
  input  wire logic [15:0] reg_rdata_q
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // host picks which flags feed the alarm
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    // data stand only in this cycle, taken before it clears
    @(posedge ref_clk);
    d = reg_rdata_q;
  endtask
endmodule
`default_nettype wire

// [verification/module_alarm_monitor_bank_tb.sv]
// Purpose: self-checking bench for the alarm bank
// Assumes: refresh period shortened to 16 cycles
// Notes:   reset checks first, then table rows, then hand tests
`timescale 1ns/10ps
`default_nettype none
`include "alarm_bank_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module module_alarm_monitor_bank_tb;
  // ****************************************
  // bench
  // ****************************************
  logic ref_clk = 1'b0, resetn = 1'b0, reg_wr, reg_rd, global_alarm_out, irq_out;
  logic [15:0] reg_addr, reg_wdata, reg_rdata_q, got;
  logic [15:0] mod_temp_code = 16'h0, mod_vcc_code = 16'h0, amp_bias_code = 16'h0;
  logic [11:0] mod_flag_cond = 12'h000;
  logic [255:0] lane_flag_cond = 256'h0, lane_bias_code = 256'h0, lane_txpwr_code = 256'h0;
  logic [255:0] lane_temp_code = 256'h0, lane_rxpwr_code = 256'h0;
  int errors, compares;
  typedef struct packed {logic [11:0] cond; logic [11:0] mask; logic glb;} row_t;
  row_t rows [5] = '{'{12'h800, 12'h000, 1'b1}, '{12'h800, 12'h800, 1'b0},
    '{12'h0F0, 12'h070, 1'b1}, '{12'h00F, 12'h00F, 1'b0}, '{12'h300, 12'h0FF, 1'b1}};
  logic [15:0] lane_exp [4] = '{16'hFFFF, 16'h0001, 16'h0019, 16'h7FFF};
  host_model u_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
  module_alarm_monitor_bank #(.REFRESH_CYCLES(24'd16)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .mod_flag_cond(mod_flag_cond), .lane_flag_cond(lane_flag_cond),
    .mod_temp_code(mod_temp_code), .mod_vcc_code(mod_vcc_code), .amp_bias_code(amp_bias_code),
    .lane_bias_code(lane_bias_code), .lane_txpwr_code(lane_txpwr_code),
    .lane_temp_code(lane_temp_code), .lane_rxpwr_code(lane_rxpwr_code),
    .global_alarm_out(global_alarm_out), .irq_out(irq_out));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic close_out;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    u_host.rd(`ADDR_MOD_FLAGS, got);
    `CHK(got, 16'h0000)
    u_host.wr(`ADDR_MOD_FLAGS, 16'hFFFF);
    u_host.rd(`ADDR_MOD_FLAGS, got);
    `CHK(got, 16'h0000)
    u_host.rd(16'h1234, got);
    `CHK(got, 16'h0000)
    $display("reset test done");
    foreach (rows[i]) begin
      @(posedge ref_clk) mod_flag_cond <= rows[i].cond;
      u_host.wr(`ADDR_MOD_MASK, {4'h0, rows[i].mask});
      repeat (2) @(posedge ref_clk);
      #1 `CHK(global_alarm_out, rows[i].glb)
      u_host.rd(`ADDR_MOD_FLAGS, got);
      `CHK(got, {4'h0, rows[i].cond})
      u_host.rd(`ADDR_MOD_MASK, got);
      `CHK(got, {4'h0, rows[i].mask})
      $display("row %0d done", i);
    end
    @(posedge ref_clk) mod_flag_cond <= 12'h000;
    lane_flag_cond[5*16 +: 16] <= 16'h0008;
    repeat (2) @(posedge ref_clk);
    #1 `CHK(global_alarm_out, 1'b1)
    u_host.rd(`ADDR_LANE_FLAGS_BASE + 16'h0005, got);
    `CHK(got, 16'h0008)
    u_host.wr(`ADDR_LANE_MASK_BASE + 16'h0005, 16'h0008);
    #1 `CHK(global_alarm_out, 1'b0)
    $display("lane test done");
    // module flag rose earlier, so its status bit is already pending
    `CHK(irq_out, 1'b0)
    u_host.wr(`ADDR_IRQ_MASK, 16'h0001);
    #1 `CHK(irq_out, 1'b1)
    u_host.wr(`ADDR_IRQ_STATUS, 16'h0001);
    #1 `CHK(irq_out, 1'b0)
    // lane rise and refresh bits are still pending
    u_host.wr(`ADDR_IRQ_MASK, 16'h0006);
    #1 `CHK(irq_out, 1'b1)
    $display("irq test done");
    @(posedge ref_clk) resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(irq_out, 1'b0)
    resetn <= 1'b1;
    mod_temp_code <= 16'h1A2B;
    mod_vcc_code <= 16'h8000;
    amp_bias_code <= 16'hFFFF;
    lane_bias_code[48 +: 16] <= 16'hFFFF;
    lane_txpwr_code[48 +: 16] <= 16'h0001;
    lane_temp_code[48 +: 16] <= 16'h0019;
    lane_rxpwr_code[48 +: 16] <= 16'h7FFF;
    // first refresh is 16 edges out, so this read sees the reset value
    u_host.rd(`ADDR_MON_MOD_TEMP, got);
    `CHK(got, 16'h0000)
    u_host.rd(`ADDR_LANE_MASK_BASE + 16'h0005, got);
    `CHK(got, 16'h0000)
    u_host.rd(`ADDR_MOD_MASK, got);
    `CHK(got, 16'h0000)
    repeat (16) @(posedge ref_clk);
    u_host.rd(`ADDR_MON_MOD_TEMP, got);
    `CHK(got, 16'h1A2B)
    u_host.rd(`ADDR_MON_MOD_VCC, got);
    `CHK(got, 16'h8000)
    u_host.rd(`ADDR_MON_AMP_BIAS, got);
    `CHK(got, 16'hFFFF)
    for (int k = 0; k < 4; k++) begin
      u_host.rd(`ADDR_LANE_MON_BASE + 16'd12 + k[15:0], got);
      `CHK(got, lane_exp[k])
    end
    // lane 5 flag rose after reset, refresh ticked, module flags idle
    u_host.rd(`ADDR_IRQ_STATUS, got);
    `CHK(got, 16'h0006)
    $display("monitor test done");
    close_out;
  end
endmodule
`default_nettype wire
